// >>> design/gpo_regs.svh
`ifndef GPO_REGS_SVH
`define GPO_REGS_SVH

// ****************************************
// Register identifiers
// ****************************************
`define SIDE_CFG_ID 7'h42
`define DUTY0_ID 7'h43
`define DUTY1_ID 7'h44
`define DUTY2_ID 7'h45
`define FAULT_STAT_ID 7'h46
`define ISO_STAT_ID 7'h47

// ****************************************
// Field positions in the fault and isolation status words
// ****************************************
`define BLOCKED_LSB 17
`define UNCONF_BIT 15
`define CH_FIELD_W 5
`define ISO_TEMP_BIT 1
`define ISO_LIM_BIT 0

// ****************************************
// Reset values
// ****************************************
`define SIDE_RST 3'h0
`define DUTY_RST 6'h00
`define UNCONF_RST 1'h1

// ****************************************
// Duty timing: 1.6 % per count, in tenths of a percent
// ****************************************
`define DUTY_STEP_PERMILLE 16
`define PWM_PERIOD_PERMILLE 1000
// Sub-ticks per count and per period: 10 and 625 share the 1.6 % ratio
`define PWM_TICKS_PER_COUNT 10'h00A
`define PWM_PERIOD_TICKS 10'h271

`endif

// >>> design/gpo_pkg.sv
`default_nettype none

package gpo_pkg;

    // Detector inputs of one output channel
    typedef struct packed {
        logic over_temp_det;
        logic over_temp_clr;
        logic current_limit_det;
        logic open_load_det;
        logic short_det;
    } chan_det_t;

    // Latched fault flags of one channel, in status-word order
    typedef struct packed {
        logic over_temp;
        logic current_limit;
        logic open_on;
        logic open_off;
        logic short_off;
    } chan_flags_t;

    // Register access request as decoded from an SPI frame
    typedef struct packed {
        logic req;
        logic wr;
        logic [6:0] id;
        logic [19:0] wdata;
    } reg_req_t;

endpackage

`default_nettype wire

// >>> design/gpo_pwm.sv
`timescale 1ns/10ps
`default_nettype none
`include "gpo_regs.svh"

module gpo_pwm
    import gpo_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Control
    input wire logic [5:0] duty,
    input wire logic enable,
    // Drive
    output logic on_q
);

    logic [9:0] tick_q;
    logic [9:0] on_ticks;

    // ****************************************
    // Period counter
    // ****************************************
    // Free-running so that duty changes take effect within one period
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            tick_q <= 10'h000;
        else if (tick_q == `PWM_PERIOD_TICKS - 10'h001)
            tick_q <= 10'h000;
        else
            tick_q <= tick_q + 10'h001;
    end

    assign on_ticks = 10'({4'h0, duty} * `PWM_TICKS_PER_COUNT);

    // ****************************************
    // Output stage
    // ****************************************
    // Counts past full scale compare above every tick, so stay fully on
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            on_q <= 1'b0;
        else
            on_q <= enable && (on_ticks > tick_q);
    end

endmodule // gpo_pwm

`default_nettype wire

// >>> design/gpo_ctrl_status.sv
`timescale 1ns/10ps
`default_nettype none
`include "gpo_regs.svh"

module gpo_ctrl_status
    import gpo_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register access from the SPI frame decoder
    input wire reg_req_t reg_in,
    output logic [19:0] reg_rdata_q,
    output logic reg_ack_q,
    // System events
    input wire logic system_state_reset,
    input wire logic reserve_boost_good,
    // Channel detectors
    input wire chan_det_t [2:0] chan_det,
    // Isolation switch detectors
    input wire logic isolation_switch_on,
    input wire logic iso_over_temp_det,
    input wire logic iso_current_limit_det,
    // Driver controls
    output logic [2:0] drive_high_side,
    output logic [2:0] drive_low_side,
    output logic [2:0] driver_side_select,
    output logic [2:0] channel_blocked
);

    // ****************************************
    // Declarations
    // ****************************************
    // Per-channel state kept in three-entry arrays
    logic [2:0] side_q;
    logic [5:0] duty_q [3];
    logic outputs_unconfigured_q;
    chan_flags_t flags_q [3];
    chan_flags_t flags_d [3];
    logic iso_temp_q;
    logic iso_lim_q;
    logic [2:0] pwm_on;
    logic [2:0] out_on;
    logic wr_side;
    logic rd_fault;
    logic rd_iso;
    logic [19:0] rd_word;

    // Latched flag update; the set always wins over a clear
    function automatic logic latch_flag(input logic cur, input logic set, input logic clr);
        latch_flag = set | (cur & ~clr);
    endfunction

    // Readback of one duty register, upper bits zero
    function automatic logic [19:0] duty_word(input logic [5:0] d);
        duty_word = {14'h0000, d};
    endfunction

    // Strobe for one kind of access to one register id
    function automatic logic hit(input reg_req_t r, input logic is_wr, input logic [6:0] id);
        hit = r.req && (r.wr == is_wr) && (r.id == id);
    endfunction

    // ****************************************
    // Access decode
    // ****************************************
    // status writes ignored
    assign wr_side = hit(reg_in, 1'b1, `SIDE_CFG_ID);
    assign rd_fault = hit(reg_in, 1'b0, `FAULT_STAT_ID);
    assign rd_iso = hit(reg_in, 1'b0, `ISO_STAT_ID);

    // ****************************************
    // Side select register
    // ****************************************
    // A state reset beats a write landing in the same cycle
    // side bits update
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            side_q <= `SIDE_RST;
        else if (system_state_reset)
            side_q <= `SIDE_RST;
        else if (wr_side)
            side_q <= reg_in.wdata[2:0];
    end

    // ****************************************
    // Duty registers
    // ****************************************
    // Writes to any other id fall through the default arm
    // per-channel duty count
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < 3; i++)
                duty_q[i] <= `DUTY_RST;
        end
        else if (system_state_reset)
        begin
            for (int i = 0; i < 3; i++)
                duty_q[i] <= `DUTY_RST;
        end
        else if (reg_in.req && reg_in.wr)
        begin
            unique case (reg_in.id)
                `DUTY0_ID: duty_q[0] <= reg_in.wdata[5:0];
                `DUTY1_ID: duty_q[1] <= reg_in.wdata[5:0];
                `DUTY2_ID: duty_q[2] <= reg_in.wdata[5:0];
                default: ;
            endcase
        end
    end

    // ****************************************
    // Configuration status
    // ****************************************
    // Any write to the side register counts, even all zeros
    // configured by side-select write
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            outputs_unconfigured_q <= `UNCONF_RST;
        else if (system_state_reset)
            outputs_unconfigured_q <= `UNCONF_RST;
        else if (wr_side)
            outputs_unconfigured_q <= 1'b0;
    end

    // ****************************************
    // Channel enable and drive
    // ****************************************
    // Thermal and configuration blocks apply in both drive modes
    // blocking causes, boost only in high-side mode
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            channel_blocked[i] = flags_q[i].over_temp || outputs_unconfigured_q ||
                (!side_q[i] && !reserve_boost_good);
        end
    end

    // One PWM generator per channel, gated by the blocked state
    for (genvar g = 0; g < 3; g++)
    begin : g_pwm
        gpo_pwm u_gpo_pwm (
            .clk(clk),
            .rst_b(rst_b),
            .duty(duty_q[g]),
            .enable(!channel_blocked[g]),
            .on_q(pwm_on[g])
        );
    end

    // A block raised mid-period stops the drive at once
    assign out_on = pwm_on & ~channel_blocked;
    assign drive_high_side = out_on & ~side_q;
    assign drive_low_side = out_on & side_q;
    assign driver_side_select = side_q;

    // ****************************************
    // Channel fault flags
    // ****************************************
    // Off means the actual drive, so PWM gaps count as off
    // limit, open and short sets gated by output state
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            // thermal cleared by its own sequence
            flags_d[i].over_temp = latch_flag(flags_q[i].over_temp,
                chan_det[i].over_temp_det, chan_det[i].over_temp_clr);
            flags_d[i].current_limit = latch_flag(flags_q[i].current_limit,
                chan_det[i].current_limit_det && out_on[i], rd_fault);
            flags_d[i].open_on = latch_flag(flags_q[i].open_on,
                chan_det[i].open_load_det && out_on[i], rd_fault);
            flags_d[i].open_off = latch_flag(flags_q[i].open_off,
                chan_det[i].open_load_det && !out_on[i], rd_fault);
            flags_d[i].short_off = latch_flag(flags_q[i].short_off,
                chan_det[i].short_det && !out_on[i], rd_fault);
        end
    end

    // State reset clears the read-clear flags but not the thermal one
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < 3; i++)
                flags_q[i] <= '0;
        end
        else if (system_state_reset)
        begin
            for (int i = 0; i < 3; i++)
                flags_q[i] <= '{over_temp: flags_d[i].over_temp, default: 1'b0};
        end
        else
        begin
            for (int i = 0; i < 3; i++)
                flags_q[i] <= flags_d[i];
        end
    end

    // ****************************************
    // Isolation switch flags
    // ****************************************
    // limit while switch on
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            iso_lim_q <= 1'b0;
        else if (system_state_reset)
            iso_lim_q <= 1'b0;
        else
            iso_lim_q <= latch_flag(iso_lim_q, iso_current_limit_det && isolation_switch_on, rd_iso);
    end

    // Not gated by the switch state: the detector reports either way
    // temperature latch
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            iso_temp_q <= 1'b0;
        else if (system_state_reset)
            iso_temp_q <= 1'b0;
        else
            iso_temp_q <= latch_flag(iso_temp_q, iso_over_temp_det, rd_iso);
    end

    // ****************************************
    // Readback
    // ****************************************
    // Ids outside the map fall to the default and read as zero
    // unused bits zero
    always_comb
    begin
        rd_word = 20'h00000;
        unique case (reg_in.id)
            `SIDE_CFG_ID: rd_word = {17'h00000, side_q};
            `DUTY0_ID: rd_word = duty_word(duty_q[0]);
            `DUTY1_ID: rd_word = duty_word(duty_q[1]);
            `DUTY2_ID: rd_word = duty_word(duty_q[2]);
            `FAULT_STAT_ID:
            begin
                rd_word[`BLOCKED_LSB +: 3] = channel_blocked;
                rd_word[`UNCONF_BIT] = outputs_unconfigured_q;
                for (int i = 0; i < 3; i++)
                    rd_word[i * `CH_FIELD_W +: `CH_FIELD_W] = flags_q[i];
            end
            `ISO_STAT_ID:
            begin
                rd_word[`ISO_TEMP_BIT] = iso_temp_q;
                rd_word[`ISO_LIM_BIT] = iso_lim_q;
            end
            default: rd_word = 20'h00000;
        endcase
    end

    // Snapshot taken on the same edge that clears, so no event is lost
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            reg_rdata_q <= 20'h00000;
        else if (reg_in.req && !reg_in.wr)
            reg_rdata_q <= rd_word;
    end

    // Ignored writes are acknowledged too, so the host never waits
    // One-cycle acknowledge for every request
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            reg_ack_q <= 1'b0;
        else
            reg_ack_q <= reg_in.req;
    end

endmodule // gpo_ctrl_status

`default_nettype wire

// >>> sim/gpo_ctrl_status_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "gpo_regs.svh"

// ******
// Port checks of the register bank
// ******
module gpo_ctrl_status_chk
    import gpo_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register access
    input wire reg_req_t reg_in,
    input wire logic [19:0] reg_rdata_q,
    // System
    input wire logic system_state_reset,
    input wire logic reserve_boost_good,
    // Driver controls
    input wire logic [2:0] drive_high_side,
    input wire logic [2:0] drive_low_side,
    input wire logic [2:0] driver_side_select,
    input wire logic [2:0] channel_blocked
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // Decoded strobes; the id alone says nothing without req
    logic rd_fault, rd_iso, rd_duty, wr_side;
    assign rd_fault = reg_in.req && !reg_in.wr && reg_in.id == `FAULT_STAT_ID;
    assign rd_iso = reg_in.req && !reg_in.wr && reg_in.id == `ISO_STAT_ID;
    assign rd_duty = reg_in.req && !reg_in.wr && reg_in.id >= `DUTY0_ID && reg_in.id <= `DUTY2_ID;
    assign wr_side = reg_in.req && reg_in.wr && reg_in.id == `SIDE_CFG_ID;

    a_hs_boost: assert property (drive_high_side != 3'h0 |-> reserve_boost_good)
        else $error("high-side drive without boost good");
    a_hs_side: assert property ((drive_high_side & driver_side_select) == 3'h0)
        else $error("high-side drive on a low-side channel");
    a_ls_side: assert property ((drive_low_side & ~driver_side_select) == 3'h0)
        else $error("low-side drive on a high-side channel");
    a_blocked_quiet: assert property (((drive_high_side | drive_low_side) & channel_blocked) == 3'h0)
        else $error("blocked channel is driven");
    a_boost_blocks: assert property (!reserve_boost_good |-> (~driver_side_select & ~channel_blocked) == 3'h0)
        else $error("high-side channel not blocked without boost");
    a_side_write: assert property (wr_side && !system_state_reset |=> driver_side_select == $past(reg_in.wdata[2:0]))
        else $error("side bits did not take the write");
    a_side_hold: assert property (!wr_side && !system_state_reset |=> $stable(driver_side_select))
        else $error("side bits changed without cause");
    a_ssr_side: assert property (system_state_reset && !reg_in.req |=> driver_side_select == 3'h0)
        else $error("state reset left side bits set");
    a_fault_top: assert property (rd_fault |=> reg_rdata_q[19:16] == {$past(channel_blocked), 1'b0})
        else $error("fault word top bits wrong");
    a_iso_pad: assert property (rd_iso |=> reg_rdata_q[19:2] == 18'h00000)
        else $error("isolation word unused bits set");
    a_duty_pad: assert property (rd_duty |=> reg_rdata_q[19:6] == 14'h0000)
        else $error("duty word unused bits set");
endmodule // gpo_ctrl_status_chk

bind gpo_ctrl_status gpo_ctrl_status_chk u_gpo_ctrl_status_chk (.clk(clk), .rst_b(rst_b),
    .reg_in(reg_in), .reg_rdata_q(reg_rdata_q), .system_state_reset(system_state_reset),
    .reserve_boost_good(reserve_boost_good), .drive_high_side(drive_high_side),
    .drive_low_side(drive_low_side), .driver_side_select(driver_side_select),
    .channel_blocked(channel_blocked));

`default_nettype wire

// >>> sim/gpo_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// ******
// Host side of the register access
// ******
module gpo_host_model
    import gpo_pkg::*;
(
    // Clock
    input wire logic clk,
    // Register access
    output var reg_req_t reg_in,
    input wire logic [19:0] reg_rdata_q,
    input wire logic reg_ack_q
);
    // Idle bus at time zero
    initial reg_in = '0;

    // One access: one-cycle strobe, answer awaited under a bound
    task automatic xfer(input logic wr, input logic [6:0] id, input logic [19:0] wd,
        output logic [19:0] rd, output logic ok);
        int i;
        ok = 1'b0;
        rd = 20'h00000;
        @(negedge clk);
        reg_in = '{req: 1'b1, wr: wr, id: id, wdata: wd};
        for (i = 0; i < 4 && ok == 1'b0; i++)
        begin
            @(negedge clk);
            // Released lines show the inverse so stale data never passes
            if (i == 0)
                reg_in = '{req: 1'b0, wr: ~wr, id: ~id, wdata: ~wd};
            if (reg_ack_q === 1'b1)
            begin
                ok = 1'b1;
                rd = reg_rdata_q;
            end
        end
    endtask
endmodule // gpo_host_model

`default_nettype wire

// >>> sim/tb_gpo_ctrl_status.sv
`timescale 1ns/10ps
`default_nettype none
`include "gpo_regs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end

module tb_gpo_ctrl_status
    import gpo_pkg::*;
;
    logic clk, rst_b, ssr, boost, iso_on;
    logic [1:0] iso_det;
    chan_det_t [2:0] det;
    reg_req_t reg_in;
    logic [19:0] rdata;
    logic ack;
    logic [2:0] hs, ls, side, blk;
    logic [5:0] duty_tab [3] = '{6'h01, 6'h3F, 6'h00};
    int miscompares, n_checks;

    // ******
    // Clock and instances
    // ******
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    gpo_ctrl_status u_gpo_ctrl_status (.clk(clk), .rst_b(rst_b), .reg_in(reg_in),
        .reg_rdata_q(rdata), .reg_ack_q(ack), .system_state_reset(ssr),
        .reserve_boost_good(boost), .chan_det(det), .isolation_switch_on(iso_on),
        .iso_over_temp_det(iso_det[1]), .iso_current_limit_det(iso_det[0]),
        .drive_high_side(hs), .drive_low_side(ls), .driver_side_select(side),
        .channel_blocked(blk));
    gpo_host_model u_gpo_host_model (.clk(clk), .reg_in(reg_in), .reg_rdata_q(rdata),
        .reg_ack_q(ack));

    // ******
    // Tasks
    // ******
    task print_verdict;
        $display("Checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // A missing answer ends the run rather than hanging it
    task acc(input logic is_wr, input logic [6:0] id, input logic [19:0] wd,
        output logic [19:0] d);
        logic ok;
        u_gpo_host_model.xfer(is_wr, id, wd, d, ok);
        if (ok !== 1'b1)
        begin
            miscompares++;
            $display("ERROR ack expected 1 seen %b", ok);
            print_verdict();
        end
    endtask
    task wr(input logic [6:0] id, input logic [19:0] wd);
        logic [19:0] d;
        acc(1'b1, id, wd, d);
    endtask
    task rd(input logic [6:0] id, input logic [19:0] e);
        logic [19:0] d;
        acc(1'b0, id, 20'h00000, d);
        `CHK($sformatf("reg %h", id), e, d)
    endtask
    // Detector and system pulses, s = {state reset, iso temp, iso limit}
    task pulse(input chan_det_t [2:0] d, input logic [2:0] s);
        @(negedge clk);
        det = d;
        {ssr, iso_det} = s;
        @(negedge clk);
        det = '0;
        {ssr, iso_det} = 3'h0;
    endtask
    // One full period seen from any phase holds exactly one on-window
    task count_on(input int e_hs, input int e_ls);
        int nh, nl, n2, nx;
        nh = 0;
        nl = 0;
        n2 = 0;
        nx = 0;
        repeat (625)
        begin
            @(negedge clk);
            nh += (hs[0] === 1'b1) ? 1 : 0;
            nl += (ls[1] === 1'b1) ? 1 : 0;
            n2 += (hs[2] !== 1'b0 || ls[2] !== 1'b0) ? 1 : 0;
            nx += $isunknown({hs, ls}) ? 1 : 0;
        end
        `CHK("on clocks ch0", e_hs, nh)
        `CHK("on clocks ch1", e_ls, nl)
        `CHK("on clocks ch2", 0, n2)
        `CHK("unknown drive clocks", 0, nx)
    endtask

    // ******
    // Sequence
    // ******
    initial
    begin
        rst_b = 1'b0;
        ssr = 1'b0;
        boost = 1'b1;
        iso_on = 1'b0;
        iso_det = 2'h0;
        det = '0;
        miscompares = 0;
        n_checks = 0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        rd(`SIDE_CFG_ID, 20'h00000);
        rd(`DUTY1_ID, 20'h00000);
        rd(`FAULT_STAT_ID, 20'hE8000);
        `CHK("blocked", 3'h7, blk)
        rd(`ISO_STAT_ID, 20'h00000);
        wr(`ISO_STAT_ID, 20'hFFFFF);
        wr(`FAULT_STAT_ID, 20'hFFFFF);
        wr(7'h40, 20'hFFFFF);
        rd(7'h40, 20'h00000);
        rd(`ISO_STAT_ID, 20'h00000);
        rd(`FAULT_STAT_ID, 20'hE8000);
        wr(`SIDE_CFG_ID, 20'hFFFFA);
        rd(`SIDE_CFG_ID, 20'h00002);
        `CHK("side select", 3'h2, side)
        boost = 1'b0;
        rd(`FAULT_STAT_ID, 20'hA0000);
        `CHK("blocked", 3'h5, blk)
        for (int i = 0; i < 3; i++)
            wr(7'(`DUTY0_ID + i), 20'hFFFC0 | {14'h0000, duty_tab[i]});
        for (int i = 0; i < 3; i++)
            rd(7'(`DUTY0_ID + i), {14'h0000, duty_tab[i]});
        count_on(0, 625);
        boost = 1'b1;
        count_on(10, 625);
        // Limit, open and short on the driven ch1 and the idle ch2
        pulse(15'h1CE0, 3'h0);
        rd(`FAULT_STAT_ID, 20'h00D80);
        rd(`FAULT_STAT_ID, 20'h00000);
        pulse(15'h0010, 3'h0);
        rd(`FAULT_STAT_ID, 20'h20010);
        rd(`FAULT_STAT_ID, 20'h20010);
        pulse(15'h0008, 3'h0);
        rd(`FAULT_STAT_ID, 20'h00000);
        // Switch off: the limit flag must stay clear
        pulse(15'h0000, 3'h3);
        rd(`ISO_STAT_ID, 20'h00002);
        iso_on = 1'b1;
        pulse(15'h0000, 3'h1);
        rd(`ISO_STAT_ID, 20'h00001);
        rd(`ISO_STAT_ID, 20'h00000);
        pulse(15'h0080, 3'h2);
        pulse(15'h0000, 3'h4);
        rd(`ISO_STAT_ID, 20'h00000);
        rd(`FAULT_STAT_ID, 20'hE8000);
        rd(`SIDE_CFG_ID, 20'h00000);
        rd(`DUTY1_ID, 20'h00000);
        print_verdict();
    end
endmodule // tb_gpo_ctrl_status

`default_nettype wire
